/* verilog/scdo_pkg.sv */
// package for the system clock divider and clock output block
// assumes a word-addressed register slave; register index times four is the byte address
package scdo_pkg;

  // register indices (byte address is four times the index)
  localparam logic [7:0] REG_CLOCK_CONTROL = 8'h8e;
  localparam logic [7:0] REG_CLOCK_DIVIDE_RATIO = 8'h95;
  localparam logic [7:0] REG_SOURCE_SELECT = 8'h96;
  localparam logic [7:0] REG_DIVIDER_STATUS = 8'h98;

  // reset values
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DIVIDE_RATIO_RESET = 8'h00;
  localparam logic [1:0] SOURCE_SELECT_RESET = 2'h0;

  // clock_control fields: bit 1 gates the pin, bits 6, 4, 3 are plain storage
  localparam int SYSCLK_OUT_ENABLE_BIT = 1;
  localparam logic [7:0] CLOCK_CONTROL_MASK = 8'h5a;

  // divide ratio
  localparam int RATIO_WIDTH = 8;
  localparam logic [7:0] RATIO_BYPASS = 8'h00;

  // status word field positions
  localparam int STAT_SYSCLK_BIT = 0;
  localparam int STAT_PWRDN_BIT = 1;
  localparam int STAT_BYPASS_BIT = 2;
  localparam int STAT_RATIO_LSB = 8;

  // oscillator sources
  typedef enum logic [1:0] {
    SRC_HIRC = 2'b00,
    SRC_EXT = 2'b01,
    SRC_LIRC = 2'b10,
    SRC_RSVD = 2'b11
  } scdo_src_e;

  // bus answer state
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANS = 1'b1
  } scdo_bus_e;

  // raw oscillator levels, sampled on clk_i
  typedef struct packed {
    logic hirc;
    logic ext;
    logic lirc;
  } scdo_osc_s;

  // divider state carried as one group
  typedef struct packed {
    logic [7:0] active;
    logic [7:0] cnt;
    logic sysclk;
    logic osc_prev;
  } scdo_div_s;

endpackage

/* verilog/scdo_top.sv */
// system clock divider with gated clock output pin and register slave
// assumes oscillator levels arrive synchronous to clk_i and far slower than it
//
// Register access over Avalon-MM was chosen for this implementation.
module scdo_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // oscillators and power state
  input wire scdo_pkg::scdo_osc_s osc_i,
  input wire logic power_down_i,
  // system clock and pin
  output logic system_clock_o,
  output logic sys_tick_o,
  output logic sysclk_out_pin_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  scdo_pkg::scdo_bus_e bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] ratio_q, ratio_d;
  scdo_pkg::scdo_src_e src_q, src_d;
  logic wr_fire;
  logic [31:0] status_word;
  scdo_pkg::scdo_div_s div_q, div_d;
  logic osc_sel;
  logic osc_rise;
  logic at_boundary;

  // one wait cycle per access, so the answer never depends on the divider
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (bus_q == scdo_pkg::BUS_IDLE);
  assign wr_fire = avs_write_i & (bus_q == scdo_pkg::BUS_ANS) & avs_byteenable_i[0];
  assign avs_readdata_o = rdata_q;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[scdo_pkg::STAT_SYSCLK_BIT] = div_q.sysclk;
    status_word[scdo_pkg::STAT_PWRDN_BIT] = power_down_i;
    status_word[scdo_pkg::STAT_BYPASS_BIT] = (div_q.active == scdo_pkg::RATIO_BYPASS);
    status_word[scdo_pkg::STAT_RATIO_LSB +: 8] = div_q.active;
  end

  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    ctl_d = ctl_q;
    ratio_d = ratio_q;
    src_d = src_q;
    case (bus_q)
      scdo_pkg::BUS_IDLE: begin
        if (avs_read_i | avs_write_i) begin
          bus_d = scdo_pkg::BUS_ANS;
        end
        if (avs_read_i) begin
          case (avs_address_i)
            scdo_pkg::REG_CLOCK_CONTROL: rdata_d = {24'h00_0000, ctl_q};
            scdo_pkg::REG_CLOCK_DIVIDE_RATIO: rdata_d = {24'h00_0000, ratio_q};
            scdo_pkg::REG_SOURCE_SELECT: rdata_d = {30'h0, src_q};
            scdo_pkg::REG_DIVIDER_STATUS: rdata_d = status_word;
            default: rdata_d = 32'h0000_0000;
          endcase
        end
      end
      scdo_pkg::BUS_ANS: begin
        bus_d = scdo_pkg::BUS_IDLE;
        if (wr_fire) begin
          case (avs_address_i)
            scdo_pkg::REG_CLOCK_CONTROL: begin
              ctl_d = avs_writedata_i[7:0] & scdo_pkg::CLOCK_CONTROL_MASK;
            end
            scdo_pkg::REG_CLOCK_DIVIDE_RATIO: ratio_d = avs_writedata_i[7:0];
            scdo_pkg::REG_SOURCE_SELECT: begin
              if (avs_writedata_i[1:0] != scdo_pkg::SRC_RSVD) begin
                src_d = scdo_pkg::scdo_src_e'(avs_writedata_i[1:0]);
              end
            end
            default: ;
          endcase
        end
      end
      default: bus_d = scdo_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus_q <= scdo_pkg::BUS_IDLE;
      rdata_q <= 32'h0000_0000;
      ctl_q <= scdo_pkg::CLOCK_CONTROL_RESET;
      ratio_q <= scdo_pkg::DIVIDE_RATIO_RESET;
      src_q <= scdo_pkg::scdo_src_e'(scdo_pkg::SOURCE_SELECT_RESET);
    end else begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      ctl_q <= ctl_d;
      ratio_q <= ratio_d;
      src_q <= src_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection and divider

  always_comb begin
    case (src_q)
      scdo_pkg::SRC_HIRC: osc_sel = osc_i.hirc;
      scdo_pkg::SRC_EXT: osc_sel = osc_i.ext;
      scdo_pkg::SRC_LIRC: osc_sel = osc_i.lirc;
      default: osc_sel = osc_i.hirc;
    endcase
  end

  assign osc_rise = osc_sel & ~div_q.osc_prev;
  assign at_boundary = osc_rise & (div_q.cnt == (div_q.active - 8'h01));

  always_comb begin
    div_d = div_q;
    // power-down freezes the whole divider, so the clock just stops
    if (!power_down_i) begin
      div_d.osc_prev = osc_sel;
      if (div_q.active == scdo_pkg::RATIO_BYPASS) begin
        div_d.sysclk = osc_sel;
        if (osc_rise) begin
          div_d.active = ratio_q;
          div_d.cnt = 8'h00;
        end
      end else if (osc_rise) begin
        if (at_boundary) begin
          div_d.cnt = 8'h00;
          div_d.sysclk = ~div_q.sysclk;
          if (!div_q.sysclk) begin
            div_d.active = ratio_q;
          end
        end else begin
          div_d.cnt = div_q.cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system clock outputs and pin

  logic pin_q, pin_d;
  logic tick_q, tick_d;
  logic pin_enable;

  assign pin_enable = ctl_q[scdo_pkg::SYSCLK_OUT_ENABLE_BIT];

  always_comb begin
    pin_d = pin_enable & ~power_down_i & div_d.sysclk;
    tick_d = ~power_down_i & div_d.sysclk & ~div_q.sysclk;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      tick_q <= tick_d;
    end
  end

  assign system_clock_o = div_q.sysclk;
  assign sys_tick_o = tick_q;
  assign sysclk_out_pin_o = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence ratio_write_s;
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
      && avs_address_i == scdo_pkg::REG_CLOCK_DIVIDE_RATIO;
  endsequence

  sequence divide_run_s;
    div_q.active != 8'h00 && !power_down_i;
  endsequence

  bypass_follow_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!srst_i && div_q.active == 8'h00 && !power_down_i) |=> div_q.sysclk == $past(osc_sel))
    else $error("bypass clock does not follow oscillator");

  ratio_toggle_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (divide_run_s and at_boundary) |=> div_q.sysclk != $past(div_q.sysclk))
    else $error("divided clock missed its toggle");

  ratio_hold_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (div_q.active != 8'h00 && !at_boundary) |=> $stable(div_q.sysclk))
    else $error("divided clock toggled early");

  count_bound_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    div_q.active != 8'h00 |-> div_q.cnt < div_q.active)
    else $error("divider count beyond ratio");

  ratio_write_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ratio_write_s |=> ratio_q == $past(avs_writedata_i[7:0]))
    else $error("ratio write not taken");

  bus_answer_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus answer later than one cycle");

  reset_clear_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $past(srst_i) |-> ratio_q == 8'h00 && div_q.active == 8'h00 && !pin_q)
    else $error("divider not clear after reset");

  pin_copy_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (pin_enable && !power_down_i) |=> sysclk_out_pin_o == div_q.sysclk)
    else $error("pin differs from system clock");

  pin_gate_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !pin_enable |=> !sysclk_out_pin_o)
    else $error("pin driven while disabled");

  pwrdn_stop_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    power_down_i |=> $stable(div_q.sysclk) && !sysclk_out_pin_o && !sys_tick_o)
    else $error("clock moved in power-down");

  // the divider must really sample the slow source, not only the mux
  source_mux_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!srst_i && src_q == scdo_pkg::SRC_LIRC && !power_down_i)
      |=> div_q.osc_prev == $past(osc_i.lirc))
    else $error("slow oscillator not selected");

  boundary_load_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $changed(div_q.active) |-> $past(osc_rise)
      && ($past(div_q.active) == 8'h00 || ($past(at_boundary) && !$past(div_q.sysclk))))
    else $error("ratio changed off a period boundary");

  sequence source_rsvd_write_s;
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
      && avs_address_i == scdo_pkg::REG_SOURCE_SELECT
      && avs_writedata_i[1:0] == scdo_pkg::SRC_RSVD;
  endsequence

  // a reserved code would only reach the mux default, which selects the fast source
  source_keep_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    source_rsvd_write_s |=> $stable(src_q))
    else $error("reserved source code stored");

  ratio_read_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (avs_read_i && avs_waitrequest_o && avs_address_i == scdo_pkg::REG_CLOCK_DIVIDE_RATIO)
      |=> avs_readdata_o == {24'h00_0000, $past(ratio_q)})
    else $error("ratio read back wrong");

  // tick is the one-cycle enable for logic running at the system clock rate
  tick_rise_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !srst_i |=> sys_tick_o == (system_clock_o && !$past(system_clock_o)))
    else $error("tick does not mark the clock rise");

endmodule

/* verif/scdo_board.sv */
// board-side load on the clock output pin: measures pin period and rises
// assumes the pin is sampled on the bench clock, which is far faster
module scdo_board (
  // clock and pin
  input wire logic clk_i,
  input wire logic pin_i,
  // measurements
  output logic [31:0] period_o,
  output logic [31:0] rises_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q = 1'b0;
  logic [31:0] cnt_q = 32'h0;
  initial begin
    period_o = 32'h0;
    rises_o = 32'h0;
  end
  always @(posedge clk_i) begin
    prev_q <= pin_i;
    cnt_q <= cnt_q + 32'h1;
    if (pin_i === 1'b1 && prev_q === 1'b0) begin
      period_o <= cnt_q;
      rises_o <= rises_o + 32'h1;
      cnt_q <= 32'h1;
    end
  end
endmodule

/* verif/scdo_top_tb.sv */
// self-checking bench for the clock divider and clock output pin
// assumes oscillators slower than clk_i; bus waits last until the slave answers
module scdo_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, srst_i, avs_read_i, avs_write_i, avs_waitrequest_o, power_down_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, p, r, period, rises;
  logic [3:0] avs_byteenable_i;
  logic system_clock_o, sys_tick_o, sysclk_out_pin_o;
  logic [7:0] cyc = 8'h0;
  logic [7:0] nl [5] = '{8'h01, 8'h02, 8'hff, 8'h00, 8'h00};
  scdo_pkg::scdo_osc_s osc_i = '0;
  int fail_count = 0, checked = 0, i;
  always #10 clk_i = ~clk_i;
  // fast, mid and slow oscillators: periods 4, 8, 16 clocks
  always @(posedge clk_i) begin
    cyc <= cyc + 8'h1;
    osc_i <= '{hirc: cyc[1], ext: cyc[2], lirc: cyc[3]};
  end
  scdo_top DUT (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .osc_i(osc_i), .power_down_i(power_down_i),
    .system_clock_o(system_clock_o), .sys_tick_o(sys_tick_o),
    .sysclk_out_pin_o(sysclk_out_pin_o));
  scdo_board board (.clk_i(clk_i), .pin_i(sysclk_out_pin_o), .period_o(period),
    .rises_o(rises));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_per(input logic [7:0] n, input logic [1:0] s);
    exp_per = ((n == 8'h00) ? 32'h1 : {23'h0, n, 1'b0}) * (32'h4 << s);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic w;
    w = 1'b1;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // read at the rising edge itself, before that edge updates the slave
    while (w !== 1'b0) begin
      @(posedge clk_i);
      w = avs_waitrequest_o;
      q = avs_readdata_o;
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // cycles between two rises of the system clock, bounded
  task automatic per();
    logic prv;
    int n, k;
    for (k = 0; k < 2; k++) begin
      n = 0;
      do begin
        prv = system_clock_o;
        @(negedge clk_i);
        n++;
        chk({31'h0, sys_tick_o}, {31'h0, prv === 1'b0 && system_clock_o === 1'b1});
      end while (!(prv === 1'b0 && system_clock_o === 1'b1) && n < 6000);
    end
    p = n;
    @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
  initial begin
    clk_i = 1'b0;
    srst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    power_down_i = 1'b0;
    i = $urandom(14);
    nl[3] = 8'h01 + 8'($urandom % 20);
    nl[4] = 8'h01 + 8'($urandom % 20);
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h95, 8'h00);
    chk(q, 32'h0);
    bus(1'b0, 8'h8e, 8'h00);
    chk(q, 32'h0);
    per();
    chk(p, exp_per(8'h00, 2'h0));
    r = rises;
    repeat (40) @(posedge clk_i);
    chk(rises, r);
    bus(1'b1, 8'h8e, 8'hff);
    bus(1'b0, 8'h8e, 8'h00);
    chk(q, 32'h5a);
    bus(1'b0, 8'h10, 8'h00);
    chk(q, 32'h0);
    for (i = 0; i < 3; i++) begin
      bus(1'b1, 8'h96, 8'(i));
      per();
      per();
      chk(p, exp_per(8'h00, 2'(i)));
    end
    bus(1'b1, scdo_pkg::REG_SOURCE_SELECT, 8'h03);
    bus(1'b0, scdo_pkg::REG_SOURCE_SELECT, 8'h00);
    chk(q, 32'h2);
    bus(1'b1, 8'h96, 8'h00);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, 8'h95, nl[i]);
      bus(1'b0, scdo_pkg::REG_CLOCK_DIVIDE_RATIO, 8'h00);
      chk(q, {24'h0, nl[i]});
      per();
      per();
      chk(p, exp_per(nl[i], 2'h0));
      chk(period, p);
    end
    bus(1'b0, scdo_pkg::REG_DIVIDER_STATUS, 8'h00);
    chk(q & 32'hffff_fffe, {16'h0, nl[4], 8'h00});
    avs_byteenable_i <= 4'he;
    bus(1'b1, scdo_pkg::REG_CLOCK_DIVIDE_RATIO, 8'h33);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, scdo_pkg::REG_CLOCK_DIVIDE_RATIO, 8'h00);
    chk(q, {24'h0, nl[4]});
    bus(1'b1, 8'h95, 8'h01);
    per();
    power_down_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    r = rises;
    p = {31'h0, system_clock_o};
    repeat (60) @(posedge clk_i);
    chk(rises, r);
    chk({31'h0, sysclk_out_pin_o}, 32'h0);
    chk({31'h0, system_clock_o}, p);
    bus(1'b0, scdo_pkg::REG_DIVIDER_STATUS, 8'h00);
    chk(q & 32'hffff_fffe, 32'h0000_0102);
    power_down_i <= 1'b0;
    bus(1'b1, 8'h8e, 8'h00);
    r = rises;
    repeat (60) @(posedge clk_i);
    chk(rises, r);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, scdo_pkg::REG_CLOCK_DIVIDE_RATIO, 8'h00);
    chk(q, 32'h0);
    bus(1'b0, scdo_pkg::REG_DIVIDER_STATUS, 8'h00);
    chk(q & 32'hffff_fffe, 32'h0000_0004);
    complete_run();
  end
endmodule
